// ### pmu_power_mode_sequencer.sv
// Behaviour
// - Regulator-enable high powers regulators and releases sections from reset.
// - Core buck, core linear, low-noise linear regulators start when reset releases.
// - All regulators go down together only when regulator-enable is low.
// - Individual regulators switch off and on with momentary demand.
// - Low-consumption mode keeps only the low-power linear regulator on.
// - Every regulator enable is driven by the sequencer.
// - Required set comes from requests, dependency table and the power-mode mask.
// - Power-up order and durations are programmable inputs, not fixed.
// - Per-resource counters run on the 32.768 kHz sequencer tick.
// - Clock source follows the mode, choosing PLL when requested and on, else crystal if on, else the low-power clock.
// - Wakeup timer is calibrated against the crystal clock.
// - Active mode runs buck efficiently for load and adjusts clocks.
// - Doze powers down radio, analog and most linear regulators.
// - Doze stops main clocks; only the low-power clock keeps running.
// - Core state is saved to retention memory before deep sleep.
// - Timer, interrupt or USB resume wake restores saved core state.
// - Power-down keeps all regulators off until regulator-enable returns.
// - Regulator-enable low holds reset with regulators disabled.
// - Each resource is off, on, turning on or turning off.
// - Timer loads duration, decrements per tick, zero load is immediate.
// - Disable unrequested resources without dependents; enable ready requested ones.
`timescale 1ns/100ps
`include "pmu_defs.svh"

module pmu_power_mode_sequencer #(
   parameter int TW = 16,
   parameter int AW = 4,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_on,
   input wire logic doze_req,
   input wire logic sleep_req,
   input wire pmu_pkg::pmu_wake_t wake_async,
   input wire logic [TW-1:0] wake_ticks,
   input wire logic fast_clk_req,
   input wire logic load_high,
   input wire logic [`PMU_N_RES-1:0] res_min,
   input wire logic [`PMU_N_RES-1:0] clk_req,
   input wire logic [`PMU_N_RES-1:0][`PMU_N_RES-1:0] dep_mask,
   input wire logic [`PMU_N_RES-1:0][TW-1:0] time_on,
   input wire logic [`PMU_N_RES-1:0][TW-1:0] time_off,
   input wire logic [DW-1:0] core_save_data,
   output logic [`PMU_N_RES-1:0] res_en,
   output pmu_pkg::pmu_res_st_t [`PMU_N_RES-1:0] res_state,
   output pmu_pkg::pmu_mode_t mode,
   output pmu_pkg::pmu_clk_sel_t clk_sel,
   output logic buck_pwm,
   output logic core_rst_n,
   output logic radio_rst_n,
   output logic lpo_run,
   output logic lpo_tick,
   output logic [AW-1:0] ret_addr,
   output logic [DW-1:0] restore_data,
   output logic restore_valid,
   output logic [`PMU_CAL_W-1:0] cal_cycles
);

   localparam int N = `PMU_N_RES;
   localparam int AC = `PMU_ACC_W;
   localparam int CW = `PMU_CAL_W;
   localparam int CL = `PMU_CAL_TICKS_LOG2;
   localparam logic [AC-1:0] LPO_STEP = AC'(`PMU_LPO_HZ);
   localparam logic [AC-1:0] CLK_WRAP = AC'(`PMU_CLK_HZ);
   localparam logic [AW-1:0] ADDR_LAST = '1;

   typedef struct packed {
      logic [AC-1:0] acc;
      logic tick;
      logic pin_on;
      pmu_pkg::pmu_mode_t mode;
      pmu_pkg::pmu_res_st_t [N-1:0] rst;
      logic [N-1:0][TW-1:0] tmr;
      logic [N-1:0] en;
      logic [TW-1:0] wake_cnt;
      logic wake_armed;
      logic [AW-1:0] addr;
      logic we;
      logic restore_valid;
      logic core_rst_n;
      logic radio_rst_n;
      pmu_pkg::pmu_clk_sel_t clk_sel;
      logic buck_pwm;
      logic [CW-1:0] cal_cnt;
      logic [CW-1:0] cal_cycles;
      logic [CL-1:0] cal_ticks;
   } pmu_state_t;

   pmu_state_t s_reg;
   pmu_state_t s_next;
   pmu_pkg::pmu_wake_t wake_sync;
   logic [DW-1:0] mem_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Wake synchroniser and retention memory.

   pmu_wake_sync #(
      .W(2)
   ) u_wake_sync (
      .clk(clk),
      .rst_n(rst_n),
      .tick(s_reg.tick),
      .async_in(wake_async),
      .sync_out(wake_sync)
   );

   pmu_ret_mem #(
      .AW(AW),
      .DW(DW)
   ) u_ret_mem (
      .clk(clk),
      .rst_n(rst_n),
      .we(s_reg.we),
      .addr(s_reg.addr),
      .wdata(core_save_data),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      logic [AC:0] acc_sum;
      logic [N-1:0] req;
      logic [N-1:0] mask;
      logic [N-1:0] on_now;
      logic [N-1:0] powered;
      logic has_dep;
      logic wake_hit;

      s_next = s_reg;
      acc_sum = '0;
      req = '0;
      mask = '0;
      on_now = '0;
      powered = '0;
      has_dep = 1'b0;
      wake_hit = 1'b0;

      // Fractional divider: the tick averages 32.768 kHz exactly, with one
      // cycle of jitter, which the per-resource durations tolerate.
      acc_sum = {1'b0, s_reg.acc} + {1'b0, LPO_STEP};
      s_next.tick = 1'b0;
      if (acc_sum >= {1'b0, CLK_WRAP}) begin
         s_next.acc = AC'(acc_sum - {1'b0, CLK_WRAP});
         s_next.tick = 1'b1;
      end else begin
         s_next.acc = acc_sum[AC-1:0];
      end

      s_next.pin_on = reg_on;
      s_next.we = 1'b0;
      s_next.restore_valid = 1'b0;

      for (int i = 0; i < N; i++) begin
         on_now[i] = (s_reg.rst[i] == pmu_pkg::PMU_R_ON);
         powered[i] = (s_reg.rst[i] != pmu_pkg::PMU_R_OFF);
      end

      wake_hit = wake_sync.ext_irq || wake_sync.usb_resume
         || (s_reg.wake_armed && (s_reg.wake_cnt == '0));

      //////////////////////////////////////////////////////////////////////
      // Power mode.

      unique case (s_reg.mode)
         pmu_pkg::PMU_M_OFF: begin
            if (s_reg.pin_on) begin
               s_next.mode = pmu_pkg::PMU_M_ACTIVE;
            end
         end
         pmu_pkg::PMU_M_ACTIVE: begin
            if (sleep_req) begin
               s_next.mode = pmu_pkg::PMU_M_SAVE;
               s_next.addr = '0;
               s_next.we = 1'b1;
            end else if (doze_req) begin
               s_next.mode = pmu_pkg::PMU_M_DOZE;
               s_next.wake_cnt = wake_ticks;
               s_next.wake_armed = (wake_ticks != '0);
            end
         end
         pmu_pkg::PMU_M_DOZE: begin
            if (wake_hit || !doze_req) begin
               s_next.mode = pmu_pkg::PMU_M_ACTIVE;
               s_next.wake_armed = 1'b0;
            end
         end
         pmu_pkg::PMU_M_SAVE: begin
            if (s_reg.addr == ADDR_LAST) begin
               s_next.mode = pmu_pkg::PMU_M_SLEEP;
               s_next.addr = '0;
               s_next.wake_cnt = wake_ticks;
               s_next.wake_armed = (wake_ticks != '0);
            end else begin
               s_next.addr = s_reg.addr + 1'b1;
               s_next.we = 1'b1;
            end
         end
         pmu_pkg::PMU_M_SLEEP: begin
            if (wake_hit) begin
               s_next.mode = pmu_pkg::PMU_M_RESTORE;
               s_next.wake_armed = 1'b0;
               s_next.addr = '0;
            end
         end
         pmu_pkg::PMU_M_RESTORE: begin
            // Reading starts only once the core switch is on again, so the
            // core never sees restored data while unpowered.
            if (on_now[`PMU_RES_CORE_SW]) begin
               s_next.restore_valid = 1'b1;
               if (s_reg.addr == ADDR_LAST) begin
                  s_next.mode = pmu_pkg::PMU_M_ACTIVE;
                  s_next.addr = '0;
               end else begin
                  s_next.addr = s_reg.addr + 1'b1;
               end
            end
         end
         default: begin
            s_next.mode = pmu_pkg::PMU_M_OFF;
         end
      endcase

      if (s_reg.tick && s_reg.wake_armed && (s_reg.wake_cnt != '0)) begin
         s_next.wake_cnt = s_reg.wake_cnt - 1'b1;
      end

      //////////////////////////////////////////////////////////////////////
      // Required resource set.

      unique case (s_reg.mode)
         pmu_pkg::PMU_M_ACTIVE,
         pmu_pkg::PMU_M_SAVE,
         pmu_pkg::PMU_M_RESTORE: mask = `PMU_MASK_ACTIVE;
         pmu_pkg::PMU_M_DOZE: mask = `PMU_MASK_DOZE;
         pmu_pkg::PMU_M_SLEEP: mask = `PMU_MASK_SLEEP;
         default: mask = `PMU_MASK_OFF;
      endcase

      req = res_min | clk_req;
      if (fast_clk_req) begin
         req[`PMU_RES_PLL] = 1'b1;
      end
      // Regulators feeding the core come up as soon as reset is released.
      req[`PMU_RES_BUCK] = 1'b1;
      req[`PMU_RES_CORE_LIN] = 1'b1;
      req[`PMU_RES_LN_LIN] = 1'b1;
      req[`PMU_RES_LP_LIN] = 1'b1;
      req[`PMU_RES_CORE_SW] = 1'b1;
      // Dependency closure; the mode mask is applied after it, so a table
      // that makes a low-power resource depend on a masked one will stall.
      for (int k = 0; k < N; k++) begin
         for (int i = 0; i < N; i++) begin
            if (req[i]) begin
               req = req | dep_mask[i];
            end
         end
      end
      req = req & mask;

      //////////////////////////////////////////////////////////////////////
      // Resource sequencing, one step per tick.

      if (s_reg.tick) begin
         for (int i = 0; i < N; i++) begin
            has_dep = 1'b0;
            for (int j = 0; j < N; j++) begin
               if (dep_mask[j][i] && powered[j] && (j != i)) begin
                  has_dep = 1'b1;
               end
            end
            unique case (s_reg.rst[i])
               pmu_pkg::PMU_R_OFF: begin
                  if (req[i] && ((dep_mask[i] & on_now) == dep_mask[i])) begin
                     if (time_on[i] == '0) begin
                        s_next.rst[i] = pmu_pkg::PMU_R_ON;
                     end else begin
                        s_next.rst[i] = pmu_pkg::PMU_R_TURN_ON;
                        s_next.tmr[i] = time_on[i];
                     end
                  end
               end
               pmu_pkg::PMU_R_TURN_ON: begin
                  s_next.tmr[i] = s_reg.tmr[i] - 1'b1;
                  if (s_reg.tmr[i] == TW'(1)) begin
                     s_next.rst[i] = pmu_pkg::PMU_R_ON;
                  end
               end
               pmu_pkg::PMU_R_ON: begin
                  if (!req[i] && !has_dep) begin
                     if (time_off[i] == '0) begin
                        s_next.rst[i] = pmu_pkg::PMU_R_OFF;
                     end else begin
                        s_next.rst[i] = pmu_pkg::PMU_R_TURN_OFF;
                        s_next.tmr[i] = time_off[i];
                     end
                  end
               end
               pmu_pkg::PMU_R_TURN_OFF: begin
                  s_next.tmr[i] = s_reg.tmr[i] - 1'b1;
                  if (s_reg.tmr[i] == TW'(1)) begin
                     s_next.rst[i] = pmu_pkg::PMU_R_OFF;
                  end
               end
            endcase
         end
      end

      //////////////////////////////////////////////////////////////////////
      // Master power pin overrides everything.

      if (!s_reg.pin_on) begin
         s_next.mode = pmu_pkg::PMU_M_OFF;
         s_next.wake_armed = 1'b0;
         s_next.addr = '0;
         s_next.we = 1'b0;
         s_next.restore_valid = 1'b0;
         for (int i = 0; i < N; i++) begin
            s_next.rst[i] = pmu_pkg::PMU_R_OFF;
            s_next.tmr[i] = '0;
         end
      end

      //////////////////////////////////////////////////////////////////////
      // Enables, resets and clocks from the next state.

      for (int i = 0; i < N; i++) begin
         // An enable rises at the start of turn-on and falls at the start
         // of turn-off; the timer covers the ramp.
         s_next.en[i] = (s_next.rst[i] == pmu_pkg::PMU_R_ON)
            || (s_next.rst[i] == pmu_pkg::PMU_R_TURN_ON);
      end

      s_next.core_rst_n = (s_next.mode != pmu_pkg::PMU_M_OFF)
         && (s_next.mode != pmu_pkg::PMU_M_SLEEP)
         && (s_next.rst[`PMU_RES_CORE_SW] == pmu_pkg::PMU_R_ON)
         && (s_next.rst[`PMU_RES_CORE_LIN] == pmu_pkg::PMU_R_ON);
      s_next.radio_rst_n = (s_next.rst[`PMU_RES_RADIO] == pmu_pkg::PMU_R_ON);

      unique case (s_next.mode)
         pmu_pkg::PMU_M_OFF,
         pmu_pkg::PMU_M_SLEEP: s_next.clk_sel = pmu_pkg::PMU_CK_GATED;
         pmu_pkg::PMU_M_DOZE: s_next.clk_sel = pmu_pkg::PMU_CK_LPO;
         default: begin
            if (fast_clk_req && (s_next.rst[`PMU_RES_PLL] == pmu_pkg::PMU_R_ON)) begin
               s_next.clk_sel = pmu_pkg::PMU_CK_PLL;
            end else if (s_next.rst[`PMU_RES_XTAL] == pmu_pkg::PMU_R_ON) begin
               s_next.clk_sel = pmu_pkg::PMU_CK_XTAL;
            end else begin
               s_next.clk_sel = pmu_pkg::PMU_CK_LPO;
            end
         end
      endcase

      // Light loads run the buck in pulse-skipping mode to save switching loss.
      s_next.buck_pwm = load_high && (s_next.mode == pmu_pkg::PMU_M_ACTIVE)
         && (s_next.rst[`PMU_RES_BUCK] == pmu_pkg::PMU_R_ON);

      //////////////////////////////////////////////////////////////////////
      // Crystal cycles per calibration window of sequencer ticks.

      if (on_now[`PMU_RES_XTAL]) begin
         s_next.cal_cnt = s_reg.cal_cnt + 1'b1;
         if (s_reg.tick) begin
            s_next.cal_ticks = s_reg.cal_ticks + 1'b1;
            if (s_reg.cal_ticks == '1) begin
               // The tick cycle itself closes the window, so it is counted here.
               s_next.cal_cycles = s_reg.cal_cnt + 1'b1;
               s_next.cal_cnt = '0;
            end
         end
      end else begin
         // A window broken by the crystal stopping is discarded.
         s_next.cal_cnt = '0;
         s_next.cal_ticks = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all taken from registers.

   assign res_en = s_reg.en;
   assign res_state = s_reg.rst;
   assign mode = s_reg.mode;
   assign clk_sel = s_reg.clk_sel;
   assign buck_pwm = s_reg.buck_pwm;
   assign core_rst_n = s_reg.core_rst_n;
   assign radio_rst_n = s_reg.radio_rst_n;
   assign lpo_run = s_reg.pin_on;
   assign lpo_tick = s_reg.tick;
   assign ret_addr = s_reg.addr;
   assign restore_data = mem_rdata;
   assign restore_valid = s_reg.restore_valid;
   assign cal_cycles = s_reg.cal_cycles;

endmodule

// ### pmu_defs.svh
`ifndef PMU_DEFS_SVH
`define PMU_DEFS_SVH

// Timing of the sequencer tick, derived from the system clock.
`define PMU_CLK_HZ 100000000
`define PMU_LPO_HZ 32768
`define PMU_ACC_W 27

// Resource map.
`define PMU_N_RES 8
`define PMU_RES_BUCK 0
`define PMU_RES_CORE_LIN 1
`define PMU_RES_LN_LIN 2
`define PMU_RES_LP_LIN 3
`define PMU_RES_XTAL 4
`define PMU_RES_PLL 5
`define PMU_RES_RADIO 6
`define PMU_RES_CORE_SW 7

// Resources each power mode allows.
`define PMU_MASK_ACTIVE 8'hff
`define PMU_MASK_DOZE 8'h88
`define PMU_MASK_SLEEP 8'h08
`define PMU_MASK_OFF 8'h00

// Wakeup timer calibration window.
`define PMU_CAL_TICKS_LOG2 3
`define PMU_CAL_W 16

`endif

// ### pmu_pkg.sv
package pmu_pkg;

   typedef enum logic [2:0] {
      PMU_M_OFF,
      PMU_M_ACTIVE,
      PMU_M_DOZE,
      PMU_M_SAVE,
      PMU_M_SLEEP,
      PMU_M_RESTORE
   } pmu_mode_t;

   typedef enum logic [1:0] {
      PMU_R_OFF,
      PMU_R_TURN_ON,
      PMU_R_ON,
      PMU_R_TURN_OFF
   } pmu_res_st_t;

   typedef enum logic [1:0] {
      PMU_CK_GATED,
      PMU_CK_LPO,
      PMU_CK_XTAL,
      PMU_CK_PLL
   } pmu_clk_sel_t;

   typedef struct packed {
      logic ext_irq;
      logic usb_resume;
   } pmu_wake_t;

endpackage

// ### pmu_wake_sync.sv
`timescale 1ns/100ps

module pmu_wake_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } pmu_sync_st_t;

   pmu_sync_st_t s_reg;
   pmu_sync_st_t s_next;

   // Both stages advance only on the sequencer tick, so a wake source
   // reaches the mode logic aligned to the slow clock.
   always_comb begin
      s_next = s_reg;
      if (tick) begin
         s_next.meta = async_in;
         s_next.sync = s_reg.meta;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sync_out = s_reg.sync;

endmodule

// ### pmu_ret_mem.sv
`timescale 1ns/100ps

module pmu_ret_mem #(
   parameter int AW = 4,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_reg;

   // The array has no reset: its contents must survive a core reset.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= mem[addr];
      end
   end

   assign rdata = rdata_reg;

endmodule

// ### pmu_power_mode_sequencer_sva.sv
`timescale 1ns/100ps
`include "pmu_defs.svh"

module pmu_power_mode_sequencer_sva #(
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic reg_on,
   input wire logic [`PMU_N_RES-1:0][`PMU_N_RES-1:0] dep_mask,
   input wire logic [`PMU_N_RES-1:0] res_en,
   input wire pmu_pkg::pmu_res_st_t [`PMU_N_RES-1:0] res_state,
   input wire pmu_pkg::pmu_mode_t mode,
   input wire pmu_pkg::pmu_clk_sel_t clk_sel,
   input wire logic core_rst_n,
   input wire logic lpo_tick,
   input wire logic [AW-1:0] ret_addr,
   input wire logic restore_valid
);
   logic [`PMU_N_RES-1:0] off_v;
   logic [`PMU_N_RES-1:0] up_v;
   logic [`PMU_N_RES-1:0] en_v;
   logic [`PMU_N_RES-1:0] dep_ok;
   logic [12:0] gap_reg;
   logic seen_reg;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      for (int i = 0; i < `PMU_N_RES; i++) begin
         off_v[i] = res_state[i] == pmu_pkg::PMU_R_OFF;
         up_v[i] = res_state[i] == pmu_pkg::PMU_R_ON;
         en_v[i] = res_state[i] inside {pmu_pkg::PMU_R_ON, pmu_pkg::PMU_R_TURN_ON};
      end
      for (int i = 0; i < `PMU_N_RES; i++) begin
         dep_ok[i] = &(~dep_mask[i] | up_v);
      end
   end

   // The first tick after reset has no reference, so spacing is judged from the second on.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gap_reg <= 13'h0;
         seen_reg <= 1'b0;
      end else if (lpo_tick) begin
         gap_reg <= 13'h1;
         seen_reg <= 1'b1;
      end else if (gap_reg != 13'h1fff) begin
         gap_reg <= gap_reg + 13'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_off_pin_low: assert property (
      !reg_on [*2] |=> mode == pmu_pkg::PMU_M_OFF && res_en == 8'h00)
      else $error("regulators up while enable pin low");
   a_on_active: assert property (
      mode == pmu_pkg::PMU_M_OFF && reg_on && $past(reg_on) && $past(rst_n)
      |=> mode == pmu_pkg::PMU_M_ACTIVE)
      else $error("no active mode after enable pin high");
   a_en_state: assert property (res_en == en_v)
      else $error("enable does not match resource state");
   a_state_tick: assert property (
      res_state != $past(res_state) |-> $past(lpo_tick) || mode == pmu_pkg::PMU_M_OFF)
      else $error("resource state moved off a tick");
   a_dep_order: assert property ((~off_v & $past(off_v) & ~$past(dep_ok)) == 8'h00)
      else $error("resource started before its dependencies");
   a_tick_gap: assert property (lpo_tick && seen_reg |-> gap_reg inside {13'hbeb, 13'hbec})
      else $error("sequencer tick spacing wrong");
   a_doze_lpo: assert property (
      mode == pmu_pkg::PMU_M_DOZE && $past(mode) == pmu_pkg::PMU_M_DOZE
      |-> clk_sel == pmu_pkg::PMU_CK_LPO)
      else $error("doze not on low-power clock");
   a_sleep_dark: assert property (
      mode == pmu_pkg::PMU_M_SLEEP && $past(mode) == pmu_pkg::PMU_M_SLEEP
      |-> clk_sel == pmu_pkg::PMU_CK_GATED && !core_rst_n)
      else $error("deep sleep clock or core reset wrong");
   a_sleep_mask: assert property (
      mode == pmu_pkg::PMU_M_SLEEP |-> (res_en & ~$past(res_en) & 8'hf7) == 8'h00)
      else $error("resource enabled in deep sleep");
   a_save_step: assert property (
      mode == pmu_pkg::PMU_M_SAVE && reg_on && $past(reg_on) && ret_addr != {AW{1'b1}}
      |=> mode == pmu_pkg::PMU_M_SAVE && ret_addr == $past(ret_addr) + 1'b1)
      else $error("save walk broken");
   a_save_end: assert property (
      mode == pmu_pkg::PMU_M_SAVE && reg_on && $past(reg_on) && ret_addr == {AW{1'b1}}
      |=> mode == pmu_pkg::PMU_M_SLEEP)
      else $error("no deep sleep after save");
   a_restore_run: assert property ($rose(restore_valid) |-> restore_valid [*8])
      else $error("restore burst broken");

   c_doze: cover property (mode == pmu_pkg::PMU_M_DOZE);
   c_sleep: cover property (mode == pmu_pkg::PMU_M_SLEEP);
   c_restore: cover property (restore_valid);
endmodule

bind pmu_power_mode_sequencer pmu_power_mode_sequencer_sva #(.AW(AW)) sva_inst (
   .clk(clk), .rst_n(rst_n), .reg_on(reg_on), .dep_mask(dep_mask), .res_en(res_en),
   .res_state(res_state), .mode(mode), .clk_sel(clk_sel), .core_rst_n(core_rst_n),
   .lpo_tick(lpo_tick), .ret_addr(ret_addr), .restore_valid(restore_valid));

// ### pmu_host_model.sv
`timescale 1ns/100ps

module pmu_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic power_cmd,
   output logic reg_on
);
   // The pin is held low in reset, as its pull-down would leave it.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_on <= 1'b0;
      end else begin
         reg_on <= power_cmd;
      end
   end
endmodule

// ### pmu_power_mode_sequencer_tb.sv
`timescale 1ns/100ps
`include "pmu_defs.svh"

module pmu_power_mode_sequencer_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic power_cmd = 1'b0;
   logic reg_on;
   logic doze_req = 1'b0;
   logic sleep_req = 1'b0;
   pmu_pkg::pmu_wake_t wake_async = '0;
   logic [15:0] wake_ticks = 16'h0;
   logic load_high = 1'b0;
   logic fast_clk_req = 1'b0;
   logic [`PMU_N_RES-1:0] res_min = 8'h00;
   logic [`PMU_N_RES-1:0][`PMU_N_RES-1:0] dep_mask = 64'h100;
   logic [`PMU_N_RES-1:0][15:0] time_on = 128'h2;
   logic [31:0] core_save_data;
   logic [7:0] res_en;
   pmu_pkg::pmu_res_st_t [7:0] res_state;
   pmu_pkg::pmu_mode_t mode;
   pmu_pkg::pmu_clk_sel_t clk_sel;
   logic buck_pwm, core_rst_n, radio_rst_n, lpo_run, lpo_tick, restore_valid;
   logic [3:0] ret_addr;
   logic [31:0] restore_data;
   logic [15:0] cal_cycles;
   int fail_count = 0;
   int tests_run = 0;
   // Whole crystal cycles in one calibration window of sequencer ticks.
   localparam int CAL_EXP = (1 << `PMU_CAL_TICKS_LOG2) * `PMU_CLK_HZ / `PMU_LPO_HZ;

   always #5 clk = ~clk;

   // Each saved word carries its own address, so a skipped or swapped word shows up.
   assign core_save_data = 32'h5a5a0000 | 32'(ret_addr);

   pmu_host_model pmu_host_model_inst (.clk(clk), .rst_n(rst_n), .power_cmd(power_cmd),
      .reg_on(reg_on));

   pmu_power_mode_sequencer pmu_power_mode_sequencer_inst (
      .clk(clk), .rst_n(rst_n), .reg_on(reg_on), .doze_req(doze_req), .sleep_req(sleep_req),
      .wake_async(wake_async), .wake_ticks(wake_ticks), .fast_clk_req(fast_clk_req),
      .load_high(load_high), .res_min(res_min), .clk_req(8'h00), .dep_mask(dep_mask),
      .time_on(time_on), .time_off(128'h0), .core_save_data(core_save_data),
      .res_en(res_en), .res_state(res_state), .mode(mode), .clk_sel(clk_sel),
      .buck_pwm(buck_pwm), .core_rst_n(core_rst_n), .radio_rst_n(radio_rst_n),
      .lpo_run(lpo_run), .lpo_tick(lpo_tick), .ret_addr(ret_addr),
      .restore_data(restore_data), .restore_valid(restore_valid), .cal_cycles(cal_cycles));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Returns one clock after the tick cycle, when resource steps have landed.
   task automatic wait_tick(input int n);
      repeat (n) begin
         for (int t = 0; t < 4000 && lpo_tick !== 1'b1; t++) cycles(1);
         cycles(1);
      end
   endtask

   task automatic wait_mode(input pmu_pkg::pmu_mode_t m, input int lim);
      for (int t = 0; t < lim && mode !== m; t++) cycles(1);
      check("mode", mode, m);
   endtask

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (95000) @(posedge clk);
      fail_count++;
      complete_run();
   end

   initial begin
      cycles(20);
      check("mode", mode, pmu_pkg::PMU_M_OFF);
      check("res_en", res_en, 8'h00);
      @(posedge clk) rst_n <= 1'b1;
      @(posedge clk) power_cmd <= 1'b1;
      load_high <= 1'b1;
      wait_mode(pmu_pkg::PMU_M_ACTIVE, 10);
      wait_tick(1);
      check("res_en", res_en, 8'h8d);
      check("buck", res_state[0], pmu_pkg::PMU_R_TURN_ON);
      check("core_rst_n", core_rst_n, 1'b0);
      wait_tick(1);
      check("buck", res_state[0], pmu_pkg::PMU_R_TURN_ON);
      wait_tick(1);
      check("buck", res_state[0], pmu_pkg::PMU_R_ON);
      check("res_en", res_en, 8'h8d);
      wait_tick(1);
      check("res_en", res_en, 8'h8f);
      cycles(2);
      check("core_rst_n", core_rst_n, 1'b1);
      check("buck_pwm", buck_pwm, 1'b1);
      check("radio_rst_n", radio_rst_n, 1'b0);
      check("clk_sel", clk_sel, pmu_pkg::PMU_CK_LPO);
      check("lpo_run", lpo_run, 1'b1);
      @(posedge clk) doze_req <= 1'b1;
      wait_mode(pmu_pkg::PMU_M_DOZE, 10);
      cycles(2);
      check("clk_sel", clk_sel, pmu_pkg::PMU_CK_LPO);
      wait_tick(1);
      check("res_en", res_en, 8'h89);
      wait_tick(1);
      check("res_en", res_en, 8'h88);
      @(posedge clk) wake_async.usb_resume <= 1'b1;
      cycles(2);
      check("mode", mode, pmu_pkg::PMU_M_DOZE);
      wait_mode(pmu_pkg::PMU_M_ACTIVE, 10000);
      @(posedge clk) doze_req <= 1'b0;
      wake_async <= '0;
      wait_tick(4);
      check("res_en", res_en, 8'h8f);
      @(posedge clk) wake_ticks <= 16'h6;
      sleep_req <= 1'b1;
      wait_mode(pmu_pkg::PMU_M_SAVE, 10);
      @(posedge clk) sleep_req <= 1'b0;
      wait_mode(pmu_pkg::PMU_M_SLEEP, 20);
      wait_tick(3);
      check("res_en", res_en, 8'h08);
      check("clk_sel", clk_sel, pmu_pkg::PMU_CK_GATED);
      wait_mode(pmu_pkg::PMU_M_RESTORE, 15000);
      for (int i = 0; i < 16; i++) begin
         for (int t = 0; t < 20000 && restore_valid !== 1'b1; t++) cycles(1);
         check("restore_valid", restore_valid, 1'b1);
         check("restore_data", restore_data, 32'h5a5a0000 | i);
         cycles(1);
      end
      wait_mode(pmu_pkg::PMU_M_ACTIVE, 10);
      @(posedge clk) power_cmd <= 1'b0;
      cycles(4);
      check("mode", mode, pmu_pkg::PMU_M_OFF);
      check("res_en", res_en, 8'h00);
      check("lpo_run", lpo_run, 1'b0);
      @(posedge clk) power_cmd <= 1'b1;
      wait_mode(pmu_pkg::PMU_M_ACTIVE, 10);
      // Crystal and fast clock are asked for only now, so that no low-power
      // mode cuts the calibration window short.
      @(posedge clk) res_min <= 8'h10;
      fast_clk_req <= 1'b1;
      wait_tick(1);
      check("res_en", res_en, 8'hbd);
      check("clk_sel", clk_sel, pmu_pkg::PMU_CK_PLL);
      @(posedge clk) fast_clk_req <= 1'b0;
      cycles(2);
      check("clk_sel", clk_sel, pmu_pkg::PMU_CK_XTAL);
      wait_tick(8);
      check("cal_cycles", cal_cycles, CAL_EXP);
      complete_run();
   end
endmodule
